// ---- hdl/sixteen_input_debounce_filter.sv ----
// Sixteen-input debounce filter with process input image
// Function
// - Low nibble codes 06h..0Ch select delays 0.4 ms to 23 ms.
// - Bit 7 clear bypasses filtering; set applies the selected delay.
// - One delay setting serves all sixteen channels alike.
// - Configuration resets to 89h: filter on, 3 ms.
// - Pulses shorter than the delay never reach the image.
// - Delay applies equally to rising and falling transitions.
// - Image byte 0 holds channels 0-7, byte 1 channels 8-15.
`timescale 1ns/1ns
`default_nettype none
module sixteen_input_debounce_filter
    import debounce_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] digital_input_channel_i,
    input  wire logic        cfg_write_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  input_delay_config_o,
    output logic             cfg_error_o,
    output logic      [7:0]  process_input_image0_o,
    output logic      [7:0]  process_input_image1_o
);
    //////////////////////////////////////////////////////////////////////
    // Configuration decode
    function automatic logic [CNT_W-1:0] code_to_cycles(
        input logic [3:0] code
    );
        case (code)
            4'h6:    code_to_cycles = CYC_0P4;
            4'h7:    code_to_cycles = CYC_0P7;
            4'h8:    code_to_cycles = CYC_1P5;
            4'h9:    code_to_cycles = CYC_3;
            4'hA:    code_to_cycles = CYC_6;
            4'hB:    code_to_cycles = CYC_12;
            4'hC:    code_to_cycles = CYC_23;
            default: code_to_cycles = CYC_3;
        endcase
    endfunction : code_to_cycles

    logic [7:0]       cfg_q;
    logic [7:0]       cfg_d;
    logic             err_q;
    logic             err_d;
    logic [15:0]      sync1_q;
    logic [15:0]      sync2_q;
    logic [15:0]      filt;
    logic [15:0]      image_q;
    wire              wr_legal;
    wire              filter_en;
    wire [CNT_W-1:0]  limit;

    // Illegal writes leave the old setting in place
    assign wr_legal = cfg_wdata_i[6:4] == CFG_RSVD_ZERO
                   && cfg_wdata_i[3:0] >= CODE_MIN
                   && cfg_wdata_i[3:0] <= CODE_MAX;
    assign cfg_d    = (cfg_write_i && wr_legal) ? cfg_wdata_i : cfg_q;
    assign err_d    = cfg_write_i ? !wr_legal : err_q;
    assign filter_en = cfg_q[CFG_ENABLE_BIT];
    assign limit    = code_to_cycles(cfg_q[3:0]);

    // Configuration register
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            cfg_q <= CFG_RESET;
            err_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            err_q <= err_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Pin synchroniser, two stages before any logic
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= digital_input_channel_i;
            sync2_q <= sync1_q;
        end
    end

    // Shared limit keeps every channel on the same timing
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
    begin : g_chan
        debounce_channel u_chan (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .sample_i  (sync2_q[ch]),
            .enable_i  (filter_en),
            .limit_i   (limit),
            .state_o   (filt[ch])
        );
    end

    //////////////////////////////////////////////////////////////////////
    // Image register, one cycle behind the filters
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            image_q <= '0;
        else
            image_q <= filt;
    end

    assign process_input_image0_o = image_q[7:0];
    assign process_input_image1_o = image_q[15:8];
    assign input_delay_config_o   = cfg_q;
    assign cfg_error_o            = err_q;

    //////////////////////////////////////////////////////////////////////
    // Assertion helper: run length of the synchronised level on channel 0.
    // It is counted apart from the filter, so a counter bug cannot hide.
    logic             hold_last_q;
    logic [CNT_W-1:0] hold_run_q;
    logic [CNT_W-1:0] hold_run_d;
    wire              hold_same = sync2_q[0] == hold_last_q;
    wire              hold_full = &hold_run_q;

    // Restart at one on a new level; saturate so a long run cannot wrap
    assign hold_run_d = !hold_same ? CNT_W'(1) :
                        hold_full  ? hold_run_q :
                        hold_run_q + CNT_W'(1);

    // Run-length tracker registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            hold_last_q <= 1'b0;
            hold_run_q  <= '0;
        end
        else
        begin
            hold_last_q <= sync2_q[0];
            hold_run_q  <= hold_run_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Assertions
    a_cfg_reset_val: assert property (@(posedge clk_sys_i)
        $fell(rst_i) |-> cfg_q == CFG_RESET)
        else $error("config not 89h after reset");

    a_bad_write_kept: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        cfg_write_i && !wr_legal |=> cfg_q == $past(cfg_q) && err_q)
        else $error("illegal code changed config");

    a_good_write_take: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        cfg_write_i && wr_legal |=> cfg_q == $past(cfg_wdata_i))
        else $error("legal code not stored");

    a_bypass_follow: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        !filter_en && $stable(filter_en) |=> filt == $past(sync2_q))
        else $error("bypass does not follow input");

    a_limit_map: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        cfg_q[3:0] == 4'h9 |-> limit == CYC_3)
        else $error("3 ms code maps wrong");

    a_short_pulse: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        filter_en && $stable(cfg_q) && $changed(filt[0])
        |-> $past(sync2_q[0], 2) == filt[0])
        else $error("channel accepted one-cycle change");

    a_image_order: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        ##1 {process_input_image1_o, process_input_image0_o}
            == $past(filt))
        else $error("image byte order wrong");

    a_uniform_time: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        filter_en && $stable(cfg_q) && $rose(filt[0]) && $rose(filt[15])
        |-> $past(sync2_q[15]) == $past(sync2_q[0]))
        else $error("channels disagree on timing");

    a_fall_filtered: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        filter_en && $stable(cfg_q) && $fell(filt[0])
        |-> !$past(sync2_q[0], 2))
        else $error("fall accepted without dwell");

    // Level must have stood for the whole selected delay before acceptance
    a_hold_full_delay: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        $past(filter_en) && $changed(filt[0])
        |-> hold_run_q >= $past(limit))
        else $error("level accepted before delay ran out");

    a_err_flag_clear: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        cfg_write_i && wr_legal |=> !err_q)
        else $error("error flag kept after legal write");

    a_cfg_idle_hold: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        !cfg_write_i |=> $stable(cfg_q) && $stable(err_q))
        else $error("config moved without a write");

    a_image_reset: assert property (@(posedge clk_sys_i)
        $fell(rst_i) |-> image_q == 16'h0000 && !err_q)
        else $error("image or error flag not clear after reset");

    c_cfg_write:  cover property (@(posedge clk_sys_i)
        cfg_write_i && wr_legal);
    c_cfg_reject: cover property (@(posedge clk_sys_i)
        cfg_write_i && !wr_legal);
    c_rise_ch0:   cover property (@(posedge clk_sys_i) $rose(filt[0]));
    c_bypass:     cover property (@(posedge clk_sys_i) !filter_en);
    c_filt_fall:  cover property (@(posedge clk_sys_i)
        filter_en && $fell(filt[0]));
endmodule : sixteen_input_debounce_filter
`default_nettype wire

// ---- hdl/debounce_pkg.sv ----
// Constants shared by the sixteen-input debounce filter design
package debounce_pkg;
    localparam int          NUM_CHANNELS   = 16;
    localparam logic [7:0]  CFG_RESET      = 8'h89;
    localparam int          CFG_ENABLE_BIT = 7;
    localparam logic [6:4]  CFG_RSVD_ZERO  = 3'h0;
    localparam logic [3:0]  CODE_MIN       = 4'h6;
    localparam logic [3:0]  CODE_MAX       = 4'hC;
    localparam int          CLK_FREQ_HZ    = 125_000_000;
    // Delay figures in microseconds, least times
    localparam int          DLY_0P4_US     = 400;
    localparam int          DLY_0P7_US     = 700;
    localparam int          DLY_1P5_US     = 1_500;
    localparam int          DLY_3_US       = 3_000;
    localparam int          DLY_6_US       = 6_000;
    localparam int          DLY_12_US      = 12_000;
    localparam int          DLY_23_US      = 23_000;
    localparam int          CNT_W          = 22;
    // Cycle counts, rounded up
    localparam logic [CNT_W-1:0] CYC_0P4 =
        CNT_W'((64'(DLY_0P4_US) * CLK_FREQ_HZ + 999_999) / 1_000_000);
    localparam logic [CNT_W-1:0] CYC_0P7 =
        CNT_W'((64'(DLY_0P7_US) * CLK_FREQ_HZ + 999_999) / 1_000_000);
    localparam logic [CNT_W-1:0] CYC_1P5 =
        CNT_W'((64'(DLY_1P5_US) * CLK_FREQ_HZ + 999_999) / 1_000_000);
    localparam logic [CNT_W-1:0] CYC_3 =
        CNT_W'((64'(DLY_3_US) * CLK_FREQ_HZ + 999_999) / 1_000_000);
    localparam logic [CNT_W-1:0] CYC_6 =
        CNT_W'((64'(DLY_6_US) * CLK_FREQ_HZ + 999_999) / 1_000_000);
    localparam logic [CNT_W-1:0] CYC_12 =
        CNT_W'((64'(DLY_12_US) * CLK_FREQ_HZ + 999_999) / 1_000_000);
    localparam logic [CNT_W-1:0] CYC_23 =
        CNT_W'((64'(DLY_23_US) * CLK_FREQ_HZ + 999_999) / 1_000_000);
endpackage : debounce_pkg

// ---- hdl/debounce_channel.sv ----
// One debounce channel: output follows input once stable for a set time
`timescale 1ns/1ns
`default_nettype none
module debounce_channel
    import debounce_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             sample_i,
    input  wire logic             enable_i,
    input  wire logic [CNT_W-1:0] limit_i,
    output logic                  state_o
);
    logic             state_q;
    logic             state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire              differs = sample_i != state_q;
    wire              expired = cnt_q >= limit_i - CNT_W'(1);

    // Same timing for rising and falling edges; a short pulse restarts
    assign state_d = !enable_i ? sample_i :
                     (differs && expired) ? sample_i : state_q;
    assign cnt_d   = (!enable_i || !differs || expired) ? '0 :
                     cnt_q + CNT_W'(1);

    // Counter and accepted level
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_q <= 1'b0;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign state_o = state_q;
endmodule : debounce_channel
`default_nettype wire

// ---- testbench/cfg_host_model.sv ----
// Head-module model that writes the configuration byte
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model
(
    input  wire logic       clk_sys_i,
    output logic            cfg_write_o,
    output logic      [7:0] cfg_wdata_o
);
    initial
    begin
        cfg_write_o = 1'b0;
        cfg_wdata_o = 8'h00;
    end
    // One-cycle strobe; data inverted after release so none stands stale
    task automatic write_cfg(input logic [7:0] data);
        @(posedge clk_sys_i);
        cfg_write_o <= 1'b1;
        cfg_wdata_o <= data;
        @(posedge clk_sys_i);
        cfg_write_o <= 1'b0;
        cfg_wdata_o <= ~data;
    endtask : write_cfg
endmodule : cfg_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the sixteen-input debounce filter
`timescale 1ns/1ns
`default_nettype none
module tb
    import debounce_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [15:0] pins      = 16'h0000;
    logic        cfg_write;
    logic [7:0]  cfg_wdata;
    logic [7:0]  cfg_q;
    logic        cfg_err;
    logic [7:0]  img0;
    logic [7:0]  img1;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    localparam int N = int'(CYC_0P4);

    initial
    begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    cfg_host_model i_host (.clk_sys_i(clk_sys_i), .cfg_write_o(cfg_write),
                           .cfg_wdata_o(cfg_wdata));
    sixteen_input_debounce_filter i_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .digital_input_channel_i(pins), .cfg_write_i(cfg_write),
        .cfg_wdata_i(cfg_wdata), .input_delay_config_o(cfg_q),
        .cfg_error_o(cfg_err), .process_input_image0_o(img0),
        .process_input_image1_o(img1));

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Write then look one edge after the answer has landed
    task automatic wr(input logic [7:0] d);
        i_host.write_cfg(d);
        @(posedge clk_sys_i);
        #1;
    endtask : wr

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : wait_cyc

    // Hang guard: tests need about 80k cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            num_errors++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        wait_cyc(20);
        rst_i <= 1'b0;
        wait_cyc(1);
        chk({8'h00, cfg_q}, 16'h0089);
        chk({img1, img0}, 16'h0000);
        chk({15'h0, cfg_err}, 16'h0000);
        // Refused bytes: bad code, reserved bits, code above range
        wr(8'h85);
        chk({7'h0, cfg_err, cfg_q}, 16'h0189);
        wr(8'hA9);
        chk({7'h0, cfg_err, cfg_q}, 16'h0189);
        wr(8'h8D);
        chk({7'h0, cfg_err, cfg_q}, 16'h0189);
        // Every documented delay code accepted with filter on
        for (int c = 6; c <= 12; c++)
        begin
            wr(8'h80 | 8'(c));
            chk({7'h0, cfg_err, cfg_q}, 16'h0080 | 16'(c));
        end
        // Bypass: image follows pins within a few edges, bytes split
        wr(8'h06);
        @(posedge clk_sys_i);
        pins <= 16'hA5C3;
        wait_cyc(8);
        chk({img1, img0}, 16'hA5C3);
        // Filter on, 0.4 ms: a short spike on every channel is dropped
        wr(8'h86);
        @(posedge clk_sys_i);
        pins <= 16'h5A3C;
        wait_cyc(30000);
        pins <= 16'hA5C3;
        wait_cyc(10);
        chk({img1, img0}, 16'hA5C3);
        // Rising and falling edges both wait the full delay
        pins <= 16'h5A3C;
        wait_cyc(N - 20);
        chk({img1, img0}, 16'hA5C3);
        wait_cyc(40);
        chk({img1, img0}, 16'h5A3C);
        // Code above range refused while filtering, old setting kept
        wr(8'h8F);
        chk({7'h0, cfg_err, cfg_q}, 16'h0186);
        // Reset in mid-run restores default and clears flag and image
        rst_i <= 1'b1;
        wait_cyc(2);
        rst_i <= 1'b0;
        wait_cyc(1);
        chk({7'h0, cfg_err, cfg_q}, 16'h0089);
        chk({img1, img0}, 16'h0000);
        summarize();
    end
endmodule : tb
`default_nettype wire
